//--- psf_defs.svh
/*
 * Offsets, field positions, reset values and timing figures of the
 * field link data map. Included by the package user modules; holds
 * definitions only.
 */
`ifndef PSF_DEFS_SVH
`define PSF_DEFS_SVH

// ----------------------------------------------------------------
// Parameter indices
// ----------------------------------------------------------------
`define PSF_IDX_STORAGE   8'h40
`define PSF_IDX_EVENTS    8'h41
`define PSF_IDX_STANDBY   8'h65
`define PSF_IDX_SOURCE    8'h67
`define PSF_IDX_TOT_PRE   8'h68
`define PSF_IDX_VSET      8'h69
`define PSF_IDX_CH_EN     8'h6A
`define PSF_IDX_TRIP      8'h6C
`define PSF_IDX_PRE       8'h6D
`define PSF_SUB_CHANNELS  8'h04

// ----------------------------------------------------------------
// Reset values (mV, mA, 0.01 %)
// ----------------------------------------------------------------
`define PSF_RST_VSET      16'h5FB4
`define PSF_RST_STANDBY   1'b0
`define PSF_RST_SOURCE    2'h2
`define PSF_RST_CH_EN     4'hF
`define PSF_RST_TRIP      16'hFFFF
`define PSF_RST_PRE       16'h1F62
`define PSF_RST_TOT_PRE   16'h4E20

// ----------------------------------------------------------------
// Cyclic image layout
// ----------------------------------------------------------------
`define PSF_PD_WIDTH      120
`define PSF_PD_TOT_LSB    104
`define PSF_PD_VOUT_LSB   88
`define PSF_PD_CH1_LSB    72
`define PSF_PD_CH2_LSB    56
`define PSF_PD_CH3_LSB    40
`define PSF_PD_CH4_LSB    24
`define PSF_PD_ON_LSB     16
`define PSF_PD_OL_LSB     8
`define PSF_PD_SC_LSB     0

// ----------------------------------------------------------------
// Event set
// ----------------------------------------------------------------
`define PSF_EVT_LOCAL_CHG 12
`define PSF_EVT_MASK      16'h27FF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PSF_CLK_MHZ       250
`define PSF_PD_PERIOD_US  2000
`define PSF_MEAS_PERIOD_US 50000

`endif

//--- psf_field_link_map.sv
/*
 * Field link data map of a multi-output supply with electronic fuses:
 * cyclic process image, indexed parameter store, 50 ms status snapshot.
 * Assumes the link stack and the local panel logic run on ref_clk and
 * hold each request for exactly one cycle; measurement inputs come
 * from logic on the same clock.
 */
`include "psf_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module psf_field_link_map
    import psf_pkg::*;
#(
    parameter int PD_CYCLES   = `PSF_PD_PERIOD_US * `PSF_CLK_MHZ,
    parameter int MEAS_CYCLES = `PSF_MEAS_PERIOD_US * `PSF_CLK_MHZ
) (
    input  wire logic                    ref_clk,
    input  wire logic                    srst,
    input  wire logic                    link_req,
    input  wire logic                    link_we,
    input  wire logic [7:0]              link_index,
    input  wire logic [7:0]              link_subindex,
    input  wire logic [15:0]             link_wdata,
    output var  logic                    link_done,
    output var  logic                    link_err,
    output var  logic [15:0]             link_rdata,
    input  wire logic                    panel_req,
    input  wire logic [7:0]              panel_index,
    input  wire logic [7:0]              panel_subindex,
    input  wire logic [15:0]             panel_wdata,
    output wire logic                    panel_taken,
    input  wire logic [15:0]             meas_total_cur,
    input  wire logic [15:0]             meas_vout,
    input  wire logic [15:0]             meas_ch1_cur,
    input  wire logic [15:0]             meas_ch2_cur,
    input  wire logic [15:0]             meas_ch3_cur,
    input  wire logic [15:0]             meas_ch4_cur,
    input  wire logic [3:0]              fuse_on,
    input  wire logic [3:0]              fuse_ol_trip,
    input  wire logic [3:0]              fuse_sc_trip,
    input  wire logic [15:0]             unit_events,
    input  wire logic [1:0]              storage_state,
    output var  logic [`PSF_PD_WIDTH-1:0] pd_image,
    output var  logic                    pd_valid,
    output var  logic                    standby,
    output var  logic [15:0]             vout_setpoint,
    output var  logic [3:0]              ch_enable,
    output wire logic [15:0]             trip_ch1,
    output wire logic [15:0]             trip_ch2,
    output wire logic [15:0]             trip_ch3,
    output wire logic [15:0]             trip_ch4,
    output wire logic [15:0]             prealarm_ch1,
    output wire logic [15:0]             prealarm_ch2,
    output wire logic [15:0]             prealarm_ch3,
    output wire logic [15:0]             prealarm_ch4,
    output var  logic [15:0]             total_prealarm
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Writable parameter at a legal subindex
    function automatic logic psf_rw_hit(input logic [7:0] idx, input logic [7:0] sub);
        logic chan;
        chan = (sub < `PSF_SUB_CHANNELS);
        case (idx)
            `PSF_IDX_STANDBY, `PSF_IDX_SOURCE, `PSF_IDX_TOT_PRE,
            `PSF_IDX_VSET, `PSF_IDX_CH_EN: psf_rw_hit = (sub == 8'h00);
            `PSF_IDX_TRIP, `PSF_IDX_PRE:   psf_rw_hit = chan;
            default:                       psf_rw_hit = 1'b0;
        endcase
    endfunction : psf_rw_hit

    // Whether the control source admits the link or the panel
    function automatic logic psf_src_admits(input psf_src_t src, input logic from_link);
        case (src)
            psf_src_panel: psf_src_admits = !from_link;
            psf_src_link:  psf_src_admits = from_link;
            psf_src_both:  psf_src_admits = 1'b1;
            default:       psf_src_admits = 1'b0;
        endcase
    endfunction : psf_src_admits

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    psf_src_t                  src_reg;
    logic [15:0]               trip_reg [4];
    logic [15:0]               pre_reg [4];
    logic [15:0]               evt_snap_reg;
    logic [1:0]                storage_snap_reg;
    logic                      panel_chg_reg;
    logic                      pd_tick;
    logic                      meas_tick;
    logic [`PSF_PD_WIDTH-1:0]  pd_next;
    logic [15:0]               rd_word;
    logic                      rd_hit;
    logic                      link_rw_hit;
    logic                      link_permit;
    logic                      link_err_c;
    logic                      link_wr_go;
    logic                      panel_go;
    logic                      acc_go;
    logic [7:0]                acc_idx;
    logic [1:0]                acc_ch;
    logic [15:0]               acc_data;
    logic                      evt_read;
    logic                      sub0;

    psf_tick_gen #(.PERIOD(PD_CYCLES)) u_pd_tick (
        .ref_clk (ref_clk),
        .srst    (srst),
        .tick    (pd_tick)
    );

    psf_tick_gen #(.PERIOD(MEAS_CYCLES)) u_meas_tick (
        .ref_clk (ref_clk),
        .srst    (srst),
        .tick    (meas_tick)
    );

    // ------------------------------------------------------------
    // Cyclic process image
    // ------------------------------------------------------------
    assign pd_next = {meas_total_cur,
                      meas_vout,
                      meas_ch1_cur, meas_ch2_cur,
                      meas_ch3_cur, meas_ch4_cur,
                      4'h0, fuse_on,
                      4'h0, fuse_ol_trip,
                      4'h0, fuse_sc_trip};

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pd_image <= '0;
            pd_valid <= 1'b0;
        end else begin
            if (pd_tick) begin
                pd_image <= pd_next;
            end
            pd_valid <= pd_tick;
        end
    end

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    assign sub0        = (link_subindex == 8'h00);
    assign link_rw_hit = psf_rw_hit(link_index, link_subindex);
    // The source selector stays link-writable, else a lock could never be undone
    assign link_permit = (link_index == `PSF_IDX_SOURCE) ? (link_wdata[15:2] == 14'h0)
                                                         : psf_src_admits(src_reg, 1'b1);
    assign link_err_c  = !rd_hit || (link_we && (!link_rw_hit || !link_permit));
    assign link_wr_go  = link_req && link_we && !link_err_c;
    assign panel_go    = panel_req && !link_wr_go
                      && psf_rw_hit(panel_index, panel_subindex)
                      && (panel_index != `PSF_IDX_SOURCE)
                      && psf_src_admits(src_reg, 1'b0);
    assign panel_taken = panel_go;
    assign acc_go      = link_wr_go || panel_go;
    assign acc_idx     = link_wr_go ? link_index : panel_index;
    assign acc_ch      = link_wr_go ? link_subindex[1:0] : panel_subindex[1:0];
    assign acc_data    = link_wr_go ? link_wdata : panel_wdata;
    assign evt_read    = link_req && !link_we && !link_err_c
                      && (link_index == `PSF_IDX_EVENTS);

    always_comb begin
        rd_word = 16'h0000;
        rd_hit  = 1'b0;
        case (link_index)
            `PSF_IDX_STORAGE: begin
                rd_hit  = sub0;
                rd_word = {14'h0000, storage_snap_reg};
            end
            `PSF_IDX_EVENTS: begin
                rd_hit  = sub0 && !link_we;
                rd_word = evt_snap_reg;
            end
            `PSF_IDX_STANDBY: begin
                rd_hit  = sub0;
                rd_word = {15'h0000, standby};
            end
            `PSF_IDX_SOURCE: begin
                rd_hit  = sub0;
                rd_word = {14'h0000, src_reg};
            end
            `PSF_IDX_TOT_PRE: begin
                rd_hit  = sub0;
                rd_word = total_prealarm;
            end
            `PSF_IDX_VSET: begin
                rd_hit  = sub0;
                rd_word = vout_setpoint;
            end
            `PSF_IDX_CH_EN: begin
                rd_hit  = sub0;
                rd_word = {12'h000, ch_enable};
            end
            `PSF_IDX_TRIP: begin
                rd_hit  = (link_subindex < `PSF_SUB_CHANNELS);
                rd_word = trip_reg[link_subindex[1:0]];
            end
            `PSF_IDX_PRE: begin
                rd_hit  = (link_subindex < `PSF_SUB_CHANNELS);
                rd_word = pre_reg[link_subindex[1:0]];
            end
            default: begin
                rd_hit  = 1'b0;
                rd_word = 16'h0000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Link answer, one cycle after the request
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            link_done  <= 1'b0;
            link_err   <= 1'b0;
            link_rdata <= 16'h0000;
        end else begin
            link_done  <= link_req;
            link_err   <= link_req && link_err_c;
            link_rdata <= (link_req && !link_we && !link_err_c) ? rd_word : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Parameter store
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            vout_setpoint  <= `PSF_RST_VSET;
            standby        <= `PSF_RST_STANDBY;
            src_reg        <= psf_src_t'(`PSF_RST_SOURCE);
            ch_enable      <= `PSF_RST_CH_EN;
            total_prealarm <= `PSF_RST_TOT_PRE;
            for (int i = 0; i < 4; i++) begin
                trip_reg[i] <= `PSF_RST_TRIP;
                pre_reg[i]  <= `PSF_RST_PRE;
            end
        end else if (acc_go) begin
            case (acc_idx)
                `PSF_IDX_VSET:    vout_setpoint  <= acc_data;
                `PSF_IDX_STANDBY: standby        <= acc_data[0];
                `PSF_IDX_SOURCE:  src_reg        <= psf_src_t'(acc_data[1:0]);
                `PSF_IDX_CH_EN:   ch_enable      <= acc_data[3:0];
                `PSF_IDX_TRIP:    trip_reg[acc_ch] <= acc_data;
                `PSF_IDX_PRE:     pre_reg[acc_ch]  <= acc_data;
                `PSF_IDX_TOT_PRE: total_prealarm <= acc_data;
                default:          standby        <= standby;
            endcase
        end
    end

    assign trip_ch1     = trip_reg[0];
    assign trip_ch2     = trip_reg[1];
    assign trip_ch3     = trip_reg[2];
    assign trip_ch4     = trip_reg[3];
    assign prealarm_ch1 = pre_reg[0];
    assign prealarm_ch2 = pre_reg[1];
    assign prealarm_ch3 = pre_reg[2];
    assign prealarm_ch4 = pre_reg[3];

    // ------------------------------------------------------------
    // 50 ms status snapshot
    // ------------------------------------------------------------
    // Panel change is sticky until the master reads the event set; a new
    // change in the clearing cycle wins so it is never lost
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            panel_chg_reg    <= 1'b0;
            evt_snap_reg     <= 16'h0000;
            storage_snap_reg <= 2'h0;
        end else begin
            panel_chg_reg <= panel_go || (panel_chg_reg && !evt_read);
            if (meas_tick) begin
                evt_snap_reg <= (unit_events & `PSF_EVT_MASK)
                              | ({15'h0000, panel_chg_reg} << `PSF_EVT_LOCAL_CHG);
                storage_snap_reg <= storage_state;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [31:0] pd_gap_reg;
    logic        pd_seen_reg;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pd_gap_reg  <= 32'h0000_0000;
            pd_seen_reg <= 1'b0;
        end else begin
            pd_gap_reg  <= pd_valid ? 32'h0000_0000 : pd_gap_reg + 32'h0000_0001;
            pd_seen_reg <= pd_seen_reg || pd_valid;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_pd_period: assert property (pd_valid && pd_seen_reg |-> pd_gap_reg == 32'(PD_CYCLES - 1))
        else $error("cyclic image period wrong");
    a_pd_head_fields: assert property (pd_tick |=> pd_valid
        && pd_image[119:104] == $past(meas_total_cur) && pd_image[103:88] == $past(meas_vout))
        else $error("total current or voltage misplaced");
    a_pd_chan_cur: assert property (pd_tick |=> pd_image[87:72] == $past(meas_ch1_cur)
        && pd_image[39:24] == $past(meas_ch4_cur) && pd_image[55:40] == $past(meas_ch3_cur))
        else $error("channel currents misplaced");
    a_pd_status_bits: assert property (pd_tick |=> pd_image[19:16] == $past(fuse_on)
        && pd_image[11:8] == $past(fuse_ol_trip) && pd_image[3:0] == $past(fuse_sc_trip))
        else $error("channel status bits misplaced");
    a_pd_hold: assert property (!pd_tick |=> $stable(pd_image))
        else $error("cyclic image changed between refreshes");
    a_snap_capture: assert property (meas_tick |=> storage_snap_reg == $past(storage_state)
        && (evt_snap_reg & `PSF_EVT_MASK) == ($past(unit_events) & `PSF_EVT_MASK))
        else $error("status snapshot not taken");
    a_snap_hold: assert property (!meas_tick |=> $stable(evt_snap_reg))
        else $error("event set changed outside snapshot");
    a_vset_write: assert property (link_wr_go && link_index == `PSF_IDX_VSET
        |=> vout_setpoint == $past(link_wdata))
        else $error("setpoint write lost");
    a_trip_write: assert property (link_wr_go && link_index == `PSF_IDX_TRIP
        && link_subindex == 8'h02 |=> trip_ch3 == $past(link_wdata))
        else $error("trip value write lost");
    a_link_locked: assert property (link_req && link_we && link_index != `PSF_IDX_SOURCE
        && (src_reg == psf_src_panel || src_reg == psf_src_none) && !panel_go
        |=> link_err && $stable(vout_setpoint) && $stable(standby))
        else $error("excluded link write took effect");
    a_event_sub: assert property (link_req && link_index == `PSF_IDX_EVENTS
        && link_subindex != 8'h00 |=> link_done && link_err)
        else $error("event flag subindex read accepted");
    a_reset_vals: assert property ($fell(srst) |-> src_reg == psf_src_both
        && ch_enable == 4'hF && vout_setpoint == 16'h5FB4 && !standby)
        else $error("wrong parameter defaults");

    c_cyclic_sent: cover property (pd_valid ##1 !pd_valid);
    c_link_write: cover property (link_wr_go ##1 link_done);
    c_panel_write: cover property (panel_go ##1 panel_chg_reg);
    c_locked_write: cover property (link_req && link_we && link_err_c);

endmodule : psf_field_link_map

`default_nettype wire

//--- psf_link_master_model.sv
/*
 * Behavioural field link master: issues one parameter request per call.
 * Assumes each request is answered one ref_clk cycle after it is taken.
 */
`timescale 1ns/1ps
`default_nettype none

module psf_link_master_model (
    input  wire logic        ref_clk,
    output var  logic        link_req,
    output var  logic        link_we,
    output var  logic [7:0]  link_index,
    output var  logic [7:0]  link_subindex,
    output var  logic [15:0] link_wdata,
    input  wire logic        link_done,
    input  wire logic        link_err,
    input  wire logic [15:0] link_rdata
);
    initial begin
        link_req      = 1'b0;
        link_we       = 1'b0;
        link_index    = 8'h00;
        link_subindex = 8'h00;
        link_wdata    = 16'h0000;
    end

    // ----------------------------------------------------------------
    // One request, answer sampled once it has settled
    // ----------------------------------------------------------------
    task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] sub,
                        input logic [15:0] wd, output logic done, output logic err,
                        output logic [15:0] rd);
        @(posedge ref_clk);
        link_req      <= 1'b1;
        link_we       <= we;
        link_index    <= idx;
        link_subindex <= sub;
        link_wdata    <= wd;
        @(posedge ref_clk);
        // Released lines show the inverse so stale values never look valid
        link_req      <= 1'b0;
        link_we       <= ~we;
        link_index    <= ~idx;
        link_subindex <= ~sub;
        link_wdata    <= ~wd;
        #1;
        done = link_done;
        err  = link_err;
        rd   = link_rdata;
    endtask : xfer
endmodule : psf_link_master_model

`default_nettype wire

//--- psf_pkg.sv
/*
 * Types shared by the field link data map modules.
 * Assumes nothing of its surroundings.
 */
package psf_pkg;

    // Control source codes, in their documented order 0..3
    typedef enum logic [1:0] {
        psf_src_panel,
        psf_src_link,
        psf_src_both,
        psf_src_none
    } psf_src_t;

    typedef logic [15:0] psf_word_t;

endpackage : psf_pkg

//--- psf_tick_gen.sv
/*
 * Free-running period divider giving one-cycle ticks.
 * Assumes a synchronous active-high reset on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module psf_tick_gen #(
    parameter int PERIOD = 500000
) (
    input  wire logic ref_clk,
    input  wire logic srst,
    output var  logic tick
);

    localparam int CW = $clog2(PERIOD);

    generate
        if (PERIOD < 2) begin : g_bad_period
            $error("psf_tick_gen: PERIOD must be at least 2");
        end
    endgenerate

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          wrap;

    assign wrap     = (cnt_reg == CW'(PERIOD - 1));
    assign cnt_next = wrap ? '0 : cnt_reg + 1'b1;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_reg <= '0;
            tick    <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick    <= wrap;
        end
    end

endmodule : psf_tick_gen

`default_nettype wire

//--- test_psf_field_link_map.sv
/*
 * Self-checking bench of the field link data map with shortened periods.
 * Assumes the link master model and the design files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module test_psf_field_link_map;
    logic         ref_clk = 1'b0;
    logic         srst = 1'b1;
    logic         link_req, link_we, link_done, link_err, panel_req, panel_taken;
    logic         pd_valid, standby;
    logic [7:0]   link_index, link_subindex, panel_index, panel_subindex;
    logic [15:0]  link_wdata, link_rdata, panel_wdata, vout_setpoint, total_prealarm;
    logic [15:0]  meas_total_cur, meas_vout, meas_ch1_cur, meas_ch2_cur, meas_ch3_cur;
    logic [15:0]  meas_ch4_cur, unit_events, trip_ch1, trip_ch2, trip_ch3, trip_ch4;
    logic [15:0]  prealarm_ch1, prealarm_ch2, prealarm_ch3, prealarm_ch4;
    logic [3:0]   fuse_on, fuse_ol_trip, fuse_sc_trip, ch_enable;
    logic [1:0]   storage_state;
    logic [119:0] pd_image;
    int           n_fail = 0;
    int           check_count = 0;
    int           cyc = 0;

    psf_field_link_map #(.PD_CYCLES(50), .MEAS_CYCLES(200)) dut_u (
        .ref_clk, .srst, .link_req, .link_we, .link_index, .link_subindex, .link_wdata,
        .link_done, .link_err, .link_rdata, .panel_req, .panel_index, .panel_subindex,
        .panel_wdata, .panel_taken, .meas_total_cur, .meas_vout, .meas_ch1_cur,
        .meas_ch2_cur, .meas_ch3_cur, .meas_ch4_cur, .fuse_on, .fuse_ol_trip, .fuse_sc_trip,
        .unit_events, .storage_state, .pd_image, .pd_valid, .standby, .vout_setpoint,
        .ch_enable, .trip_ch1, .trip_ch2, .trip_ch3, .trip_ch4, .prealarm_ch1, .prealarm_ch2,
        .prealarm_ch3, .prealarm_ch4, .total_prealarm);
    psf_link_master_model mst_u (.ref_clk, .link_req, .link_we, .link_index,
        .link_subindex, .link_wdata, .link_done, .link_err, .link_rdata);

    always #2 ref_clk = ~ref_clk;

    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [119:0] exp, input logic [119:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic results;
        if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results

    // Ceiling well above the roughly 400 cycles the sequence needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end

    task automatic acc(input logic we, input logic [7:0] idx, input logic [7:0] sub,
                       input logic [15:0] wd, input logic exp_err, input logic [15:0] exp_rd);
        logic        done;
        logic        err;
        logic [15:0] rd;
        mst_u.xfer(we, idx, sub, wd, done, err, rd);
        chk("link_done", 1'b1, done);
        chk("link_err", exp_err, err);
        if (!we && !exp_err) chk("link_rdata", exp_rd, rd);
    endtask : acc

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_defaults;
        chk("vout_setpoint", 16'h5FB4, vout_setpoint);
        chk("standby", 1'b0, standby);
        chk("ch_enable", 4'hF, ch_enable);
        chk("total_prealarm", 16'h4E20, total_prealarm);
        chk("trip_ch1_3", {3{16'hFFFF}}, {trip_ch1, trip_ch2, trip_ch3});
        chk("prealarm_ch2_4", {3{16'h1F62}}, {prealarm_ch2, prealarm_ch3, prealarm_ch4});
        acc(1'b0, 8'h67, 8'h00, 16'h0000, 1'b0, 16'h0002);
        acc(1'b0, 8'h68, 8'h00, 16'h0000, 1'b0, 16'h4E20);
        for (int s = 0; s < 4; s++) begin
            acc(1'b0, 8'h6C, s[7:0], 16'h0000, 1'b0, 16'hFFFF);
            acc(1'b0, 8'h6D, s[7:0], 16'h0000, 1'b0, 16'h1F62);
        end
    endtask : t_defaults

    task automatic t_writes;
        acc(1'b1, 8'h69, 8'h00, 16'h6000, 1'b0, 16'h0000);
        acc(1'b0, 8'h69, 8'h00, 16'h0000, 1'b0, 16'h6000);
        chk("vout_setpoint", 16'h6000, vout_setpoint);
        acc(1'b1, 8'h65, 8'h00, 16'h0001, 1'b0, 16'h0000);
        chk("standby", 1'b1, standby);
        acc(1'b1, 8'h6C, 8'h03, 16'h1234, 1'b0, 16'h0000);
        chk("trip_ch4", 16'h1234, trip_ch4);
        acc(1'b1, 8'h6C, 8'h02, 16'h5678, 1'b0, 16'h0000);
        chk("trip_ch3", 16'h5678, trip_ch3);
        acc(1'b1, 8'h6D, 8'h00, 16'h0FA0, 1'b0, 16'h0000);
        chk("prealarm_ch1", 16'h0FA0, prealarm_ch1);
        acc(1'b1, 8'h68, 8'h00, 16'h2710, 1'b0, 16'h0000);
        chk("total_prealarm", 16'h2710, total_prealarm);
    endtask : t_writes

    task automatic t_refused;
        acc(1'b1, 8'h40, 8'h00, 16'h0001, 1'b1, 16'h0000);
        acc(1'b1, 8'h41, 8'h00, 16'h0001, 1'b1, 16'h0000);
        acc(1'b0, 8'h41, 8'h01, 16'h0000, 1'b1, 16'h0000);
        acc(1'b0, 8'h42, 8'h00, 16'h0000, 1'b1, 16'h0000);
        acc(1'b1, 8'h67, 8'h00, 16'h0004, 1'b1, 16'h0000);
    endtask : t_refused

    task automatic t_source;
        logic link_ok;
        logic panel_ok;
        logic exp_sb;
        // Standby was left set by the write scenario
        exp_sb = 1'b1;
        for (int s = 0; s < 4; s++) begin
            link_ok  = (s == 1 || s == 2);
            panel_ok = (s == 0 || s == 2);
            acc(1'b1, 8'h67, 8'h00, s[15:0], 1'b0, 16'h0000);
            acc(1'b1, 8'h6A, 8'h00, {12'h000, s[3:0]}, ~link_ok, 16'h0000);
            chk("ch_enable", link_ok ? s[3:0] : 4'hF, ch_enable);
            if (link_ok) acc(1'b1, 8'h6A, 8'h00, 16'h000F, 1'b0, 16'h0000);
            @(posedge ref_clk);
            panel_req   <= 1'b1;
            panel_wdata <= 16'h0000;
            #1;
            chk("panel_taken", panel_ok, panel_taken);
            @(posedge ref_clk);
            panel_req <= 1'b0;
            #1;
            if (panel_ok) exp_sb = 1'b0;
            chk("standby", exp_sb, standby);
            acc(1'b1, 8'h65, 8'h00, 16'h0001, ~link_ok, 16'h0000);
            if (link_ok) exp_sb = 1'b1;
            chk("standby", exp_sb, standby);
        end
        acc(1'b1, 8'h67, 8'h00, 16'h0002, 1'b0, 16'h0000);
    endtask : t_source

    task automatic t_image;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (pd_valid !== 1'b1 && n < 60);
        chk("pd_image", {16'hA1B2, 16'h5DC0, 16'h1111, 16'h2222, 16'h3333, 16'h4444,
            8'h05, 8'h0A, 8'h0C}, pd_image);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (pd_valid !== 1'b1 && n < 60);
        chk("pd_period", 50, n);
    endtask : t_image

    task automatic t_snapshot;
        repeat (210) @(posedge ref_clk);
        acc(1'b0, 8'h40, 8'h00, 16'h0000, 1'b0, 16'h0001);
        acc(1'b0, 8'h41, 8'h00, 16'h0000, 1'b0, 16'h37FF);
    endtask : t_snapshot

    initial begin
        panel_req      = 1'b0;
        panel_index    = 8'h65;
        panel_subindex = 8'h00;
        panel_wdata    = 16'h0000;
        meas_total_cur = 16'hA1B2;
        meas_vout      = 16'h5DC0;
        meas_ch1_cur   = 16'h1111;
        meas_ch2_cur   = 16'h2222;
        meas_ch3_cur   = 16'h3333;
        meas_ch4_cur   = 16'h4444;
        fuse_on        = 4'h5;
        fuse_ol_trip   = 4'hA;
        fuse_sc_trip   = 4'hC;
        unit_events    = 16'hFFFF;
        storage_state  = 2'h1;
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        t_defaults();
        t_writes();
        t_refused();
        t_source();
        t_image();
        t_snapshot();
        results();
    end
endmodule : test_psf_field_link_map

`default_nettype wire
